/* File: gdoc_top.sv */
`timescale 1ns/1ps
`include "gdoc_regs.svh"
module gdoc_top #(
    parameter int RETRY_LONG_CYC = `GDOC_RETRY_LONG_MS * 1000000 / `GDOC_CLK_NS
) (
    input wire logic clk, // 10 MHz core clock
    input wire logic sys_rst, // Async reset, high
    input wire logic reg_wr, // Register write strobe
    input wire logic reg_rd, // Register read strobe
    input wire logic [3:0] reg_addr, // Register address
    input wire logic [10:0] reg_wdata, // Write data
    output logic [10:0] reg_rdata, // Read data, held
    input wire logic clear_fault, // Explicit fault clear pulse
    input wire logic pwm_hi_in, // High-side PWM pin
    input wire logic pwm_lo_in, // Low-side PWM pin
    input wire logic drain_source_overcurrent, // Drain-source comparator
    input wire logic shunt_overcurrent, // Shunt comparator
    output logic gate_hi, // High-side gate command
    output logic gate_lo, // Low-side gate command
    output logic ls_peak_en, // Low-side peak current window
    output logic [3:0] ls_source_current_sel, // Source current code
    output logic [3:0] ls_sink_current_sel, // Sink current code
    output logic [3:0] drain_source_trip_sel, // Trip threshold code
    output logic fault_active, // Protective fault active
    output logic oc_report, // Overcurrent reported
    output logic [2:0] lock_code // Lock field
);
    localparam int RETRY_SHORT_CYC = `GDOC_RETRY_SHORT_US * 1000 / `GDOC_CLK_NS;

    // ==========================================================
    // Timing helpers
    function automatic int cyc_up(input int ns);
        int c;
        c = (ns + `GDOC_CLK_NS - 1) / `GDOC_CLK_NS;
        return (c < 1) ? 1 : c;
    endfunction : cyc_up

    function automatic logic [7:0] scaled_cyc(input int base_ns, input logic [1:0] code);
        return 8'(cyc_up(base_ns << code));
    endfunction : scaled_cyc

    // ==========================================================
    // Registers
    logic [10:0] lsgd_q, lsgd_d;
    logic [10:0] occ_q, occ_d;
    logic [2:0] lock_q, lock_d;
    logic [10:0] rdata_q, rdata_d;
    logic locked;

    always_comb begin
        lsgd_d = lsgd_q;
        occ_d = occ_q;
        lock_d = lock_q;
        rdata_d = rdata_q;
        locked = (lock_q == `GDOC_LOCK_SET);
        if (reg_wr) begin
            if (reg_addr == `GDOC_LOCK_ADDR) begin
                if (!locked && reg_wdata[`GDOC_LOCK_HI:`GDOC_LOCK_LO] == `GDOC_LOCK_SET) begin
                    lock_d = `GDOC_LOCK_SET;
                end else if (locked &&
                             reg_wdata[`GDOC_LOCK_HI:`GDOC_LOCK_LO] == `GDOC_LOCK_CLR) begin
                    lock_d = `GDOC_LOCK_CLR;
                end
            end
            if (!locked && reg_addr == `GDOC_LSGD_ADDR) begin
                lsgd_d = reg_wdata;
            end
            if (!locked && reg_addr == `GDOC_OCC_ADDR) begin
                occ_d = reg_wdata;
            end
        end
        if (reg_rd) begin
            unique case (reg_addr)
                `GDOC_LOCK_ADDR: rdata_d = {lock_q, 8'h00};
                `GDOC_LSGD_ADDR: rdata_d = lsgd_q;
                `GDOC_OCC_ADDR: rdata_d = occ_q;
                default: rdata_d = 11'h000;
            endcase
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            lsgd_q <= `GDOC_LSGD_RST;
            occ_q <= `GDOC_OCC_RST;
            lock_q <= `GDOC_LOCK_RST;
            rdata_q <= 11'h000;
        end else begin
            lsgd_q <= lsgd_d;
            occ_q <= occ_d;
            lock_q <= lock_d;
            rdata_q <= rdata_d;
        end
    end

    // ==========================================================
    // Pin synchronisers
    logic [3:0] sync1_q, sync2_q;
    logic [1:0] pwm_prev_q;
    logic hi_s, lo_s, ds_s, sh_s, pwm_edge;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            sync1_q <= 4'h0;
            sync2_q <= 4'h0;
            pwm_prev_q <= 2'h0;
        end else begin
            sync1_q <= {pwm_hi_in, pwm_lo_in, drain_source_overcurrent, shunt_overcurrent};
            sync2_q <= sync1_q;
            pwm_prev_q <= sync2_q[3:2];
        end
    end

    assign hi_s = sync2_q[3];
    assign lo_s = sync2_q[2];
    assign ds_s = sync2_q[1];
    assign sh_s = sync2_q[0];
    assign pwm_edge = |(sync2_q[3:2] ^ pwm_prev_q);

    // ==========================================================
    // Deglitch and fault response
    gdoc_pkg::gdoc_resp_t resp;
    gdoc_pkg::gdoc_flt_t flt_q, flt_d;
    logic [7:0] ds_cnt_q, ds_cnt_d, sh_cnt_q, sh_cnt_d, deg_cyc;
    logic [23:0] retry_q, retry_d;
    logic report_q, report_d, detect, cbc_on;

    assign resp = gdoc_pkg::gdoc_resp_t'(occ_q[`GDOC_MODE_HI:`GDOC_MODE_LO]);

    always_comb begin
        deg_cyc = scaled_cyc(`GDOC_DEG_BASE_US * 1000, occ_q[`GDOC_DEG_HI:`GDOC_DEG_LO]);
        ds_cnt_d = ds_s ? ((ds_cnt_q < deg_cyc) ? ds_cnt_q + 8'h01 : ds_cnt_q) : 8'h00;
        sh_cnt_d = sh_s ? ((sh_cnt_q < deg_cyc) ? sh_cnt_q + 8'h01 : sh_cnt_q) : 8'h00;
        detect = (ds_cnt_q >= deg_cyc) || (sh_cnt_q >= deg_cyc);
        cbc_on = lsgd_q[`GDOC_CBC_BIT] && (resp == gdoc_pkg::GDOC_RESP_RETRY);
        flt_d = flt_q;
        retry_d = (retry_q != 24'h000000) ? retry_q - 24'h000001 : retry_q;
        // An active fault stays reported even if the mode is changed under it
        report_d = (flt_q != gdoc_pkg::GDOC_FLT_IDLE) ||
                   (detect && resp != gdoc_pkg::GDOC_RESP_OFF);
        unique case (flt_q)
            gdoc_pkg::GDOC_FLT_IDLE: begin
                if (detect && resp == gdoc_pkg::GDOC_RESP_LATCH) begin
                    flt_d = gdoc_pkg::GDOC_FLT_LATCHED;
                end else if (detect && resp == gdoc_pkg::GDOC_RESP_RETRY) begin
                    flt_d = gdoc_pkg::GDOC_FLT_RETRY;
                    retry_d = occ_q[`GDOC_RETRY_BIT] ? 24'(RETRY_SHORT_CYC) :
                                                       24'(RETRY_LONG_CYC);
                end
            end
            gdoc_pkg::GDOC_FLT_LATCHED: begin
                if (clear_fault && !detect) begin
                    flt_d = gdoc_pkg::GDOC_FLT_IDLE;
                end
            end
            gdoc_pkg::GDOC_FLT_RETRY: begin
                if (retry_q <= 24'h000001 || (cbc_on && pwm_edge)) begin
                    flt_d = gdoc_pkg::GDOC_FLT_IDLE;
                    retry_d = 24'h000000;
                end
            end
            default: flt_d = gdoc_pkg::GDOC_FLT_IDLE;
        endcase
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            flt_q <= gdoc_pkg::GDOC_FLT_IDLE;
            ds_cnt_q <= 8'h00;
            sh_cnt_q <= 8'h00;
            retry_q <= 24'h000000;
            report_q <= 1'b0;
        end else begin
            flt_q <= flt_d;
            ds_cnt_q <= ds_cnt_d;
            sh_cnt_q <= sh_cnt_d;
            retry_q <= retry_d;
            report_q <= report_d;
        end
    end

    // ==========================================================
    // Gate sequencing with dead time and peak window
    logic gh_q, gh_d, gl_q, gl_d, block, want_h, want_l;
    logic [7:0] dead_q, dead_d, peak_q, peak_d;

    // A fault in report-only mode never reaches this gate
    assign block = (flt_q != gdoc_pkg::GDOC_FLT_IDLE);

    always_comb begin
        want_h = hi_s && !lo_s && !block;
        want_l = lo_s && !hi_s && !block;
        dead_d = (dead_q != 8'h00) ? dead_q - 8'h01 : dead_q;
        gh_d = want_h && (gh_q || (!gl_q && dead_q == 8'h00));
        gl_d = want_l && (gl_q || (!gh_q && dead_q == 8'h00));
        if ((gh_q && !gh_d) || (gl_q && !gl_d)) begin
            dead_d = scaled_cyc(`GDOC_DEAD_BASE_NS, occ_q[`GDOC_DEAD_HI:`GDOC_DEAD_LO]);
        end
        peak_d = (peak_q != 8'h00) ? peak_q - 8'h01 : peak_q;
        if (gl_d && !gl_q) begin
            peak_d = scaled_cyc(`GDOC_DRIVE_BASE_NS, lsgd_q[`GDOC_TDRV_HI:`GDOC_TDRV_LO]);
        end else if (!gl_d) begin
            peak_d = 8'h00;
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            gh_q <= 1'b0;
            gl_q <= 1'b0;
            dead_q <= 8'h00;
            peak_q <= 8'h00;
        end else begin
            gh_q <= gh_d;
            gl_q <= gl_d;
            dead_q <= dead_d;
            peak_q <= peak_d;
        end
    end

    // ==========================================================
    // Outputs
    logic peak_en_q, peak_en_d, fault_q, fault_d;

    always_comb begin
        peak_en_d = (peak_d != 8'h00);
        fault_d = (flt_d != gdoc_pkg::GDOC_FLT_IDLE);
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            peak_en_q <= 1'b0;
            fault_q <= 1'b0;
        end else begin
            peak_en_q <= peak_en_d;
            fault_q <= fault_d;
        end
    end

    assign reg_rdata = rdata_q;
    assign gate_hi = gh_q;
    assign gate_lo = gl_q;
    assign ls_peak_en = peak_en_q;
    assign ls_source_current_sel = lsgd_q[`GDOC_SRC_HI:`GDOC_SRC_LO];
    assign ls_sink_current_sel = lsgd_q[`GDOC_SNK_HI:`GDOC_SNK_LO];
    assign drain_source_trip_sel = occ_q[`GDOC_TRIP_HI:`GDOC_TRIP_LO];
    assign fault_active = fault_q;
    assign oc_report = report_q;
    assign lock_code = lock_q;
endmodule : gdoc_top

/* File: gdoc_regs.svh */
`ifndef GDOC_REGS_SVH
`define GDOC_REGS_SVH

// ==========================================================
// Register offsets
`define GDOC_LOCK_ADDR 4'h3
`define GDOC_LSGD_ADDR 4'h4
`define GDOC_OCC_ADDR 4'h5

// ==========================================================
// Field positions
`define GDOC_LOCK_HI 10
`define GDOC_LOCK_LO 8
`define GDOC_CBC_BIT 10
`define GDOC_TDRV_HI 9
`define GDOC_TDRV_LO 8
`define GDOC_SRC_HI 7
`define GDOC_SRC_LO 4
`define GDOC_SNK_HI 3
`define GDOC_SNK_LO 0
`define GDOC_RETRY_BIT 10
`define GDOC_DEAD_HI 9
`define GDOC_DEAD_LO 8
`define GDOC_MODE_HI 7
`define GDOC_MODE_LO 6
`define GDOC_DEG_HI 5
`define GDOC_DEG_LO 4
`define GDOC_TRIP_HI 3
`define GDOC_TRIP_LO 0

// ==========================================================
// Reset values and lock codes
`define GDOC_LSGD_RST 11'h7FF
`define GDOC_OCC_RST 11'h169
`define GDOC_LOCK_RST 3'h3
`define GDOC_LOCK_SET 3'h6
`define GDOC_LOCK_CLR 3'h3

// ==========================================================
// Timing
`define GDOC_CLK_NS 100
`define GDOC_DRIVE_BASE_NS 500
`define GDOC_DEAD_BASE_NS 50
`define GDOC_DEG_BASE_US 1
`define GDOC_RETRY_LONG_MS 8
`define GDOC_RETRY_SHORT_US 50

`endif

/* File: gdoc_pkg.sv */
package gdoc_pkg;
    typedef enum logic [1:0] {
        GDOC_RESP_LATCH,
        GDOC_RESP_RETRY,
        GDOC_RESP_REPORT,
        GDOC_RESP_OFF
    } gdoc_resp_t;
    typedef enum logic [1:0] {
        GDOC_FLT_IDLE,
        GDOC_FLT_LATCHED,
        GDOC_FLT_RETRY
    } gdoc_flt_t;
endpackage : gdoc_pkg

/* File: gdoc_assertions.sv */
`timescale 1ns/1ps
// ====
// Register bus and gate checks
module gdoc_chk #(
    parameter int RETRY_LONG_CYC = 80000
) (
    input wire logic clk, // Core clock
    input wire logic sys_rst, // Async reset
    input wire logic reg_wr, // Write strobe
    input wire logic reg_rd, // Read strobe
    input wire logic [3:0] reg_addr, // Address
    input wire logic [10:0] reg_wdata, // Write data
    input wire logic [10:0] reg_rdata, // Read data
    input wire logic gate_hi, // High gate
    input wire logic gate_lo, // Low gate
    input wire logic ls_peak_en, // Peak window
    input wire logic [3:0] ls_source_current_sel, // Source code
    input wire logic [3:0] ls_sink_current_sel, // Sink code
    input wire logic fault_active, // Fault
    input wire logic oc_report, // Report
    input wire logic [2:0] lock_code // Lock field
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    a_rd_drive: assert property (reg_rd && reg_addr == 4'h4 |=>
        reg_rdata[7:0] == {$past(ls_source_current_sel), $past(ls_sink_current_sel)})
        else $error("drive register read mismatch");
    a_rd_unmapped: assert property (reg_rd && reg_addr > 4'h5 |=> reg_rdata == 11'h000)
        else $error("unmapped read not zero");
    a_lock_hold: assert property (lock_code == 3'h6 && reg_wr && reg_addr == 4'h4 |=>
        $stable(ls_sink_current_sel)) else $error("write passed lock");
    a_lock_enter: assert property (lock_code == 3'h3 && reg_wr && reg_addr == 4'h3 &&
        reg_wdata[10:8] == 3'h6 |=> lock_code == 3'h6) else $error("lock not taken");
    a_lock_ignore: assert property (reg_wr && reg_addr == 4'h3 &&
        !(reg_wdata[10:8] inside {3'h3, 3'h6}) |=> $stable(lock_code))
        else $error("odd lock code acted on");
    a_fault_gates: assert property (fault_active [*2] |-> !gate_hi && !gate_lo)
        else $error("gate on during fault");
    a_fault_report: assert property (fault_active [*2] |-> oc_report)
        else $error("fault not reported");
    a_no_overlap: assert property (!(gate_hi && gate_lo))
        else $error("both gates on");
    a_dead_gap: assert property ($fell(gate_hi) |-> !gate_lo ##1 !gate_lo)
        else $error("dead gap too short");
    a_peak_start: assert property ($rose(gate_lo) |-> ##[0:1] ls_peak_en)
        else $error("peak window missing");
    cover property (fault_active ##1 !fault_active);
    cover property ($rose(gate_lo));
    cover property (lock_code == 3'h6 && reg_wr);
endmodule : gdoc_chk

bind gdoc_top gdoc_chk #(.RETRY_LONG_CYC(RETRY_LONG_CYC)) u_chk (.*);

/* File: gdoc_ctrl_model.sv */
`timescale 1ns/1ps
// ====
// Controller side of the register port
module gdoc_ctrl_model (
    input wire logic clk, // Core clock
    input wire logic [10:0] reg_rdata, // Read data
    output logic reg_wr, // Write strobe
    output logic reg_rd, // Read strobe
    output logic [3:0] reg_addr, // Address
    output logic [10:0] reg_wdata // Write data
);
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 4'hF;
        reg_wdata = 11'h000;
    end
    task wr(input logic [3:0] a, input logic [10:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clk);
        reg_wr = 1'b0;
        reg_wdata = ~d; // Stale data must not look valid
    endtask : wr
    task rd(input logic [3:0] a, output logic [10:0] q);
        @(negedge clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clk);
        reg_rd = 1'b0;
        @(negedge clk);
        q = reg_rdata;
    endtask : rd
endmodule : gdoc_ctrl_model

/* File: gdoc_tb.sv */
`timescale 1ns/1ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin err_count++; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, g, e); end end
module testbench;
    typedef struct {logic [3:0] a; logic [10:0] d; logic [10:0] e;} gdoc_row_t;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic clear_fault = 1'b0;
    logic pwm_hi_in = 1'b0;
    logic pwm_lo_in = 1'b0;
    logic [1:0] oc_in = 2'b00;
    logic reg_wr;
    logic reg_rd;
    logic [3:0] reg_addr;
    logic [10:0] reg_wdata;
    logic [10:0] reg_rdata;
    logic [10:0] q;
    logic gate_hi;
    logic gate_lo;
    logic ls_peak_en;
    logic fault_active;
    logic oc_report;
    logic [3:0] src_sel;
    logic [3:0] snk_sel;
    logic [3:0] trip_sel;
    logic [2:0] lock_code;
    int err_count = 0;
    int n_tests = 0;
    // Unmapped write must read back zero
    gdoc_row_t rows [6] = '{'{4'h4, 11'h123, 11'h123}, '{4'h5, 11'h2A5, 11'h2A5},
        '{4'h4, 11'h000, 11'h000}, '{4'h5, 11'h7FF, 11'h7FF},
        '{4'h7, 11'h555, 11'h000}, '{4'h3, 11'h000, 11'h300}};
    always #50 clk = ~clk;
    gdoc_ctrl_model ctl (.clk(clk), .reg_rdata(reg_rdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata));
    // Short long-retry keeps the run brief
    gdoc_top #(.RETRY_LONG_CYC(200)) uut (.clk(clk), .sys_rst(sys_rst), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .clear_fault(clear_fault), .pwm_hi_in(pwm_hi_in), .pwm_lo_in(pwm_lo_in),
        .drain_source_overcurrent(oc_in[1]), .shunt_overcurrent(oc_in[0]),
        .gate_hi(gate_hi), .gate_lo(gate_lo), .ls_peak_en(ls_peak_en),
        .ls_source_current_sel(src_sel), .ls_sink_current_sel(snk_sel),
        .drain_source_trip_sel(trip_sel), .fault_active(fault_active), .oc_report(oc_report),
        .lock_code(lock_code));
    task cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc
    task oc_on(input logic [10:0] v, input int n, input logic [1:0] s);
        ctl.wr(4'h5, v);
        oc_in = s;
        cyc(n);
    endtask : oc_on
    task close_out;
        $display("tests=%0d errors=%0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : close_out
    initial begin
        #3000000;
        err_count++;
        close_out();
    end
    initial begin
        cyc(8);
        sys_rst = 1'b0;
        foreach (rows[i]) begin
            ctl.wr(rows[i].a, rows[i].d);
            ctl.rd(rows[i].a, q);
            `CHK(q, rows[i].e)
        end
        $display("table done");
        sys_rst = 1'b1;
        cyc(2);
        sys_rst = 1'b0;
        ctl.rd(4'h4, q);
        `CHK(q, 11'h7FF)
        ctl.rd(4'h5, q);
        `CHK(q, 11'h169)
        ctl.rd(4'h3, q);
        `CHK(q, 11'h300)
        `CHK(src_sel, 4'hF)
        `CHK(trip_sel, 4'h9)
        $display("reset done");
        ctl.wr(4'h3, 11'h600);
        `CHK(lock_code, 3'h6)
        ctl.wr(4'h4, 11'h0AA);
        ctl.rd(4'h4, q);
        `CHK(q, 11'h7FF)
        ctl.wr(4'h3, 11'h500);
        ctl.rd(4'h3, q);
        `CHK(q, 11'h600)
        ctl.wr(4'h3, 11'h300);
        ctl.wr(4'h4, 11'h0AA);
        ctl.rd(4'h4, q);
        `CHK(q, 11'h0AA)
        `CHK(snk_sel, 4'hA)
        pwm_lo_in = 1'b1;
        cyc(5);
        `CHK(ls_peak_en, 1'b1)
        cyc(7);
        `CHK({gate_lo, ls_peak_en}, 2'b10)
        pwm_lo_in = 1'b0;
        $display("lock and drive done");
        // Dead code 11b: gap of five edges, then a 40 cycle peak window
        ctl.wr(4'h5, 11'h7C9);
        ctl.wr(4'h4, 11'h3AA);
        pwm_hi_in = 1'b1;
        cyc(5);
        `CHK(gate_hi, 1'b1)
        pwm_hi_in = 1'b0;
        pwm_lo_in = 1'b1;
        cyc(3);
        `CHK({gate_hi, gate_lo}, 2'b00)
        cyc(4);
        `CHK({gate_hi, gate_lo}, 2'b00)
        cyc(1);
        `CHK({gate_lo, ls_peak_en}, 2'b11)
        cyc(39);
        `CHK(ls_peak_en, 1'b1)
        cyc(1);
        `CHK(ls_peak_en, 1'b0)
        pwm_lo_in = 1'b0;
        $display("dead time done");
        ctl.wr(4'h4, 11'h7FF);
        for (int m = 0; m < 4; m++) begin
            oc_on({1'b1, 2'b00, m[1:0], 2'b00, 4'h9}, 20, 2'b01);
            `CHK(fault_active, m < 2)
            `CHK(oc_report, m != 3)
            oc_in = 2'b00;
            cyc(4);
            pwm_hi_in = ~pwm_hi_in;
            cyc(6);
            `CHK(fault_active, m == 0)
            clear_fault = 1'b1;
            cyc(1);
            clear_fault = 1'b0;
            cyc(3);
            `CHK(fault_active, 1'b0)
        end
        $display("modes done");
        ctl.wr(4'h4, 11'h3FF);
        oc_on(11'h049, 20, 2'b10);
        oc_in = 2'b00;
        cyc(4);
        pwm_lo_in = 1'b1;
        cyc(6);
        `CHK(fault_active, 1'b1)
        cyc(200);
        `CHK(fault_active, 1'b0)
        pwm_lo_in = 1'b0;
        oc_on(11'h4B9, 60, 2'b11);
        `CHK(oc_report, 1'b0)
        cyc(30);
        `CHK(oc_report, 1'b1)
        oc_in = 2'b00;
        cyc(4);
        // Short retry with cycle clear off: fault holds 500 cycles
        oc_on(11'h449, 20, 2'b01);
        oc_in = 2'b00;
        cyc(485);
        `CHK(fault_active, 1'b1)
        cyc(15);
        `CHK(fault_active, 1'b0)
        $display("retry and filter done");
        close_out();
    end
endmodule : testbench
